/* tmc_pkg.sv */
package tmc_pkg;

	localparam int          TMC_ADR_W  = 8;
	localparam int          TMC_DAT_W  = 32;
	localparam int          TMC_MATCHN = 4;
	localparam int          TMC_CAPN   = 2;
	localparam int          TMC_FLAG_W = 7;

	localparam logic [7:0]  OFS_FLAGS     = 8'h00;
	localparam logic [7:0]  OFS_CONTROL   = 8'h04;
	localparam logic [7:0]  OFS_COUNT     = 8'h08;
	localparam logic [7:0]  OFS_DIV_LIMIT = 8'h0C;
	localparam logic [7:0]  OFS_DIV_COUNT = 8'h10;
	localparam logic [7:0]  OFS_MATCH_ACT = 8'h14;
	localparam logic [7:0]  OFS_MATCH_0   = 8'h18;
	localparam logic [7:0]  OFS_MATCH_1   = 8'h1C;
	localparam logic [7:0]  OFS_MATCH_2   = 8'h20;
	localparam logic [7:0]  OFS_MATCH_3   = 8'h24;
	localparam logic [7:0]  OFS_CAP_CTRL  = 8'h28;
	localparam logic [7:0]  OFS_CAPTURE_0 = 8'h2C;
	localparam logic [7:0]  OFS_CAPTURE_1 = 8'h30;
	localparam logic [7:0]  OFS_EXT_MATCH = 8'h3C;
	localparam logic [7:0]  OFS_MODE      = 8'h70;
	localparam logic [7:0]  OFS_PWM       = 8'h74;
	localparam logic [7:0]  OFS_IRQ_MASK  = 8'h78;

	localparam logic [31:0] TMC_RESET_VAL = 32'h0000_0000;

	localparam int          CTRL_RUN_BIT   = 0;
	localparam int          CTRL_CLEAR_BIT = 1;
	localparam int          FLAG_CAP0_BIT  = 4;
	localparam int          FLAG_CAP1_BIT  = 5;
	localparam int          MACT_INT       = 0;
	localparam int          MACT_RESET     = 1;
	localparam int          MACT_STOP      = 2;
	localparam int          MACT_STRIDE    = 3;
	localparam int          CCTL_RISE      = 0;
	localparam int          CCTL_FALL      = 1;
	localparam int          CCTL_INT       = 2;
	localparam int          CCTL_STRIDE    = 3;
	localparam int          EXT_ACT_LSB    = 4;
	localparam int          MODE_SEL_BIT   = 2;

	typedef enum logic [1:0] {
		TMC_TIMER = 2'h0,
		TMC_RISE  = 2'h1,
		TMC_FALL  = 2'h2,
		TMC_BOTH  = 2'h3
	} tmc_mode_t;

	typedef enum logic [1:0] {
		TMC_EXT_KEEP   = 2'h0,
		TMC_EXT_CLEAR  = 2'h1,
		TMC_EXT_SET    = 2'h2,
		TMC_EXT_TOGGLE = 2'h3
	} tmc_ext_act_t;

endpackage

/* tmc_edge_sync.sv */
`timescale 1ns/1ps
module tmc_edge_sync (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);
	import tmc_pkg::*;

	logic meta;
	logic sync;
	logic sync_q;

	// meta feeds sync only; edges come from the settled pair
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta   <= 1'b0;
			sync   <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta   <= pin_i;
			sync   <= meta;
			sync_q <= sync;
		end
	end

	assign rise_o = sync & ~sync_q;
	assign fall_o = ~sync & sync_q;

endmodule

/* tmc_timer.sv */
// Summary of operation
// - count advances once per divider_limit plus one clocks in timer mode, or counted edges in edge modes
// - divider reaching its limit bumps the count and clears divider
// - divider_count is readable and writable over the bus
// - timer_control holds run and clear, both zero after reset
// - each match enables reset, stop and flag actions independently
// - selected capture edge copies timer_count into its capture value
// - capture_control picks edges and flag enable per capture input
// - external_match_control drives the four match outputs on matches
// - count_mode_select picks timer mode or edge counting of an input
// - pulse_width_control turns on PWM per match output
// - flags read one while pending; match 0..3 bits 0..3, capture0 bit 4
// - writing one clears a flag; zero leaves it
// - capture1 flag position is a per-instance parameter, here bit 5
// - registers at listed offsets, all used bits reset to zero
// - while clear bit is one both counters held at zero
// - count wraps from all ones to zero with no flag
// - stop match halts both counters and clears counter_run
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module tmc_timer #(
	parameter int unsigned CAP1_FLAG_BIT = tmc_pkg::FLAG_CAP1_BIT
) (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [tmc_pkg::TMC_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [tmc_pkg::TMC_DAT_W-1:0] wb_dat_i,
	output logic      [tmc_pkg::TMC_DAT_W-1:0] wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic                        capture_input_0_i,
	input  wire logic                        capture_input_1_i,
	output logic      [tmc_pkg::TMC_MATCHN-1:0] match_output_o,
	output logic                             irq_o
);
	import tmc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [31:0]           timer_count;
	logic [31:0]           divider_count;
	logic [31:0]           divider_limit;
	logic [1:0]            timer_control;
	logic [11:0]           match_action_control;
	logic [31:0]           match_value [TMC_MATCHN];
	logic [5:0]            capture_control;
	logic [31:0]           capture_value [TMC_CAPN];
	logic [3:0]            ext_state;
	logic [7:0]            ext_action;
	logic [2:0]            count_mode_select;
	logic [3:0]            pulse_width_control;
	logic [TMC_FLAG_W-1:0] interrupt_flags;
	logic [TMC_FLAG_W-1:0] irq_mask;
	logic [3:0]            hit_q;

	////////////////////////////////////////////////////////////////////////
	wire        req      = wb_cyc_i & wb_stb_i;
	wire        wr_en    = req & wb_we_i & wb_ack_o;
	wire [31:0] lane     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire        wr_flags = wr_en && wb_adr_i == OFS_FLAGS;
	wire        wr_ctrl  = wr_en && wb_adr_i == OFS_CONTROL;
	wire        wr_count = wr_en && wb_adr_i == OFS_COUNT;
	wire        wr_limit = wr_en && wb_adr_i == OFS_DIV_LIMIT;
	wire        wr_div   = wr_en && wb_adr_i == OFS_DIV_COUNT;
	wire        wr_mact  = wr_en && wb_adr_i == OFS_MATCH_ACT;
	wire        wr_cctl  = wr_en && wb_adr_i == OFS_CAP_CTRL;
	wire        wr_ext   = wr_en && wb_adr_i == OFS_EXT_MATCH;
	wire        wr_mode  = wr_en && wb_adr_i == OFS_MODE;
	wire        wr_pwm   = wr_en && wb_adr_i == OFS_PWM;
	wire        wr_mask  = wr_en && wb_adr_i == OFS_IRQ_MASK;
	wire [3:0]  wr_match = {wr_en && wb_adr_i == OFS_MATCH_3,
	                        wr_en && wb_adr_i == OFS_MATCH_2,
	                        wr_en && wb_adr_i == OFS_MATCH_1,
	                        wr_en && wb_adr_i == OFS_MATCH_0};

	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [31:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	wire [31:0] wr_word = merge(32'h0000_0000, wb_dat_i, lane);

	////////////////////////////////////////////////////////////////////////
	logic [TMC_CAPN-1:0] cap_rise;
	logic [TMC_CAPN-1:0] cap_fall;

	tmc_edge_sync u_cap0 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (capture_input_0_i),
		.rise_o (cap_rise[0]),
		.fall_o (cap_fall[0])
	);

	tmc_edge_sync u_cap1 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (capture_input_1_i),
		.rise_o (cap_rise[1]),
		.fall_o (cap_fall[1])
	);

	////////////////////////////////////////////////////////////////////////
	wire       run      = timer_control[CTRL_RUN_BIT];
	wire       clearing = timer_control[CTRL_CLEAR_BIT];
	wire       src_rise = cap_rise[count_mode_select[MODE_SEL_BIT]];
	wire       src_fall = cap_fall[count_mode_select[MODE_SEL_BIT]];
	wire [1:0] mode_raw = count_mode_select[1:0];
	tmc_mode_t mode;
	assign mode = tmc_mode_t'(mode_raw);
	wire       cnt_edge = (mode == TMC_RISE && src_rise) ||
	                      (mode == TMC_FALL && src_fall) ||
	                      (mode == TMC_BOTH && (src_rise || src_fall));
	wire       step     = run && !clearing &&
	                      (mode == TMC_TIMER || cnt_edge);
	wire       div_hit  = divider_count == divider_limit;

	logic [3:0] hit;
	logic [3:0] match_evt;
	logic [3:0] int_en;
	logic [3:0] reset_en;
	logic [3:0] stop_en;
	always_comb begin
		for (int n = 0; n < TMC_MATCHN; n++) begin
			hit[n]      = timer_count == match_value[n];
			int_en[n]   = match_action_control[n*MACT_STRIDE+MACT_INT];
			reset_en[n] = match_action_control[n*MACT_STRIDE+MACT_RESET];
			stop_en[n]  = match_action_control[n*MACT_STRIDE+MACT_STOP];
		end
		match_evt = hit & ~hit_q;
	end

	wire reset_hit = |(hit & reset_en);
	wire stop_evt  = |(match_evt & stop_en);

	////////////////////////////////////////////////////////////////////////
	logic [31:0] next_timer_count;
	logic [31:0] next_divider_count;
	always_comb begin
		next_timer_count   = timer_count;
		next_divider_count = divider_count;
		if (clearing) begin
			next_timer_count   = 32'h0000_0000;
			next_divider_count = 32'h0000_0000;
		end else begin
			if (step && !stop_evt) begin
				next_divider_count = div_hit ? 32'h0000_0000 :
				                     divider_count + 32'h0000_0001;
				if (div_hit)
					next_timer_count = reset_hit ? 32'h0000_0000 :
					                   timer_count + 32'h0000_0001;
			end
			if (wr_count)
				next_timer_count = merge(timer_count, wb_dat_i, lane);
			if (wr_div)
				next_divider_count = merge(divider_count, wb_dat_i, lane);
		end
	end

	logic [1:0] next_timer_control;
	always_comb begin
		next_timer_control = timer_control;
		if (wr_ctrl)
			next_timer_control = wb_dat_i[1:0] & lane[1:0] |
			                     timer_control & ~lane[1:0];
		if (stop_evt)
			next_timer_control[CTRL_RUN_BIT] = 1'b0;
	end

	logic [3:0]          next_ext_state;
	logic [TMC_CAPN-1:0] cap_evt;
	logic [TMC_FLAG_W-1:0] ev_set;
	always_comb begin
		next_ext_state = wr_ext ? (wr_word[3:0] | ext_state & ~lane[3:0]) :
		                          ext_state;
		for (int n = 0; n < TMC_MATCHN; n++) begin
			if (match_evt[n]) begin
				case (tmc_ext_act_t'(ext_action[2*n +: 2]))
				TMC_EXT_CLEAR:  next_ext_state[n] = 1'b0;
				TMC_EXT_SET:    next_ext_state[n] = 1'b1;
				TMC_EXT_TOGGLE: next_ext_state[n] = ~ext_state[n];
				default:        next_ext_state[n] = next_ext_state[n];
				endcase
			end
		end
		for (int c = 0; c < TMC_CAPN; c++) begin
			cap_evt[c] =
				(capture_control[c*CCTL_STRIDE+CCTL_RISE] & cap_rise[c]) |
				(capture_control[c*CCTL_STRIDE+CCTL_FALL] & cap_fall[c]);
		end
		ev_set = '0;
		ev_set[3:0] = match_evt & int_en;
		ev_set[FLAG_CAP0_BIT] = cap_evt[0] &
		                        capture_control[CCTL_INT];
		ev_set[CAP1_FLAG_BIT] = cap_evt[1] &
		                        capture_control[CCTL_STRIDE+CCTL_INT];
	end

	wire [TMC_FLAG_W-1:0] flag_clr =
		wr_flags ? wr_word[TMC_FLAG_W-1:0] : '0;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_count   <= TMC_RESET_VAL;
			divider_count <= TMC_RESET_VAL;
			timer_control <= 2'h0;
			hit_q         <= 4'h0;
		end else begin
			timer_count   <= next_timer_count;
			divider_count <= next_divider_count;
			timer_control <= next_timer_control;
			hit_q         <= hit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			interrupt_flags <= '0;
			ext_state       <= 4'h0;
		end else begin
			interrupt_flags <= (interrupt_flags & ~flag_clr) | ev_set;
			ext_state       <= next_ext_state;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			divider_limit        <= TMC_RESET_VAL;
			match_action_control <= 12'h000;
			capture_control      <= 6'h00;
			ext_action           <= 8'h00;
			count_mode_select    <= 3'h0;
			pulse_width_control  <= 4'h0;
			irq_mask             <= '0;
		end else begin
			if (wr_limit)
				divider_limit <= merge(divider_limit, wb_dat_i, lane);
			if (wr_mact)
				match_action_control <= wr_word[11:0] |
				                        match_action_control & ~lane[11:0];
			if (wr_cctl)
				capture_control <= wr_word[5:0] | capture_control & ~lane[5:0];
			if (wr_ext)
				ext_action <= wr_word[11:4] | ext_action & ~lane[11:4];
			if (wr_mode)
				count_mode_select <= wr_word[2:0] |
				                     count_mode_select & ~lane[2:0];
			if (wr_pwm)
				pulse_width_control <= wr_word[3:0] |
				                       pulse_width_control & ~lane[3:0];
			if (wr_mask)
				irq_mask <= wr_word[TMC_FLAG_W-1:0] |
				            irq_mask & ~lane[TMC_FLAG_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		for (int n = 0; n < TMC_MATCHN; n++) begin
			if (rst_i)
				match_value[n] <= TMC_RESET_VAL;
			else if (wr_match[n])
				match_value[n] <= merge(match_value[n], wb_dat_i, lane);
		end
		for (int c = 0; c < TMC_CAPN; c++) begin
			if (rst_i)
				capture_value[c] <= TMC_RESET_VAL;
			else if (cap_evt[c])
				capture_value[c] <= timer_count;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [3:0] next_match_out;
	always_comb begin
		for (int n = 0; n < TMC_MATCHN; n++) begin
			next_match_out[n] = pulse_width_control[n] ?
			                    timer_count >= match_value[n] : ext_state[n];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_output_o <= 4'h0;
			irq_o          <= 1'b0;
		end else begin
			match_output_o <= next_match_out;
			irq_o          <= |(interrupt_flags & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic [31:0] rd_word;
	always_comb begin
		case (wb_adr_i)
		OFS_FLAGS:     rd_word = {25'h0, interrupt_flags};
		OFS_CONTROL:   rd_word = {30'h0, timer_control};
		OFS_COUNT:     rd_word = timer_count;
		OFS_DIV_LIMIT: rd_word = divider_limit;
		OFS_DIV_COUNT: rd_word = divider_count;
		OFS_MATCH_ACT: rd_word = {20'h0, match_action_control};
		OFS_MATCH_0:   rd_word = match_value[0];
		OFS_MATCH_1:   rd_word = match_value[1];
		OFS_MATCH_2:   rd_word = match_value[2];
		OFS_MATCH_3:   rd_word = match_value[3];
		OFS_CAP_CTRL:  rd_word = {26'h0, capture_control};
		OFS_CAPTURE_0: rd_word = capture_value[0];
		OFS_CAPTURE_1: rd_word = capture_value[1];
		OFS_EXT_MATCH: rd_word = {20'h0, ext_action, ext_state};
		OFS_MODE:      rd_word = {29'h0, count_mode_select};
		OFS_PWM:       rd_word = {28'h0, pulse_width_control};
		OFS_IRQ_MASK:  rd_word = {25'h0, irq_mask};
		default:       rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			if (req & ~wb_ack_o)
				wb_dat_o <= rd_word;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence bus_req_s;
		req && !wb_ack_o;
	endsequence

	sequence ack_once_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	sequence plain_tick_s;
		step && div_hit && !stop_evt && !reset_hit && !wr_count &&
		!wr_div && !clearing;
	endsequence

	bus_ack_a: assert property (bus_req_s |=> ack_once_s)
		else $error("bus ack not a single pulse");
	div_wrap_a: assert property (plain_tick_s |=> divider_count == 0 &&
		timer_count == $past(timer_count) + 32'h0000_0001)
		else $error("divider terminal did not bump count");
	div_step_a: assert property (step && !div_hit && !clearing &&
		!wr_div && !stop_evt |=>
		divider_count == $past(divider_count) + 32'h0000_0001)
		else $error("divider did not advance");
	clear_hold_a: assert property (clearing && !wr_ctrl [*2] |->
		timer_count == 0 && divider_count == 0)
		else $error("counters not held at zero while clearing");
	count_wrap_a: assert property (plain_tick_s ##0
		timer_count == 32'hFFFF_FFFF |=> timer_count == 0 &&
		$stable(interrupt_flags))
		else $error("count did not wrap quietly");
	stop_match_a: assert property (stop_evt |=> !run &&
		$stable(timer_count) && $stable(divider_count))
		else $error("stop match left counter running");
	idle_hold_a: assert property (!run && !wr_count && !clearing |=>
		$stable(timer_count))
		else $error("count moved while disabled");
	capture_load_a: assert property (cap_evt[0] |=>
		capture_value[0] == $past(timer_count))
		else $error("capture 0 did not load count");
	flag_w1c_a: assert property (wr_flags && ev_set == 0 |=>
		interrupt_flags == ($past(interrupt_flags) & ~$past(flag_clr)))
		else $error("flag write-one-clear wrong");
	flag_set_wins_a: assert property (ev_set != 0 |=>
		(interrupt_flags & $past(ev_set)) == $past(ev_set))
		else $error("event flag lost");
	irq_level_a: assert property ((interrupt_flags & irq_mask) != 0 |=>
		irq_o)
		else $error("pending unmasked flag without interrupt");

endmodule

/* tb_timer32_match_capture.sv */
`timescale 1ns/1ps
module tb_timer32_match_capture;
	import tmc_pkg::*;

	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_wdat;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        cap0;
	logic        cap1;
	logic [3:0]  match_output_o;
	logic        irq_o;
	logic [31:0] rd;
	int          err_count;
	int          n_compared;
	int          n;

	tmc_timer #(.CAP1_FLAG_BIT(5)) dut_u (
		.clk_i             (clk_i),
		.rst_i             (rst_i),
		.wb_cyc_i          (wb_cyc),
		.wb_stb_i          (wb_stb),
		.wb_we_i           (wb_we),
		.wb_adr_i          (wb_adr),
		.wb_sel_i          (wb_sel),
		.wb_dat_i          (wb_wdat),
		.wb_dat_o          (wb_dat_o),
		.wb_ack_o          (wb_ack_o),
		.capture_input_0_i (cap0),
		.capture_input_1_i (cap1),
		.match_output_o    (match_output_o),
		.irq_o             (irq_o)
	);

	initial clk_i = 1'b0;
	always #2.5 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one classic cycle; entered just after a rising edge
	task automatic wb_xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= w;
		wb_adr  <= a;
		wb_sel  <= 4'hF;
		wb_wdat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		q = wb_dat_o;
		if (k >= 50) chk("bus ack", 32'h1, 32'h0);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb_xfer(1'b1, a, d, q);
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a,
			input logic [31:0] e);
		logic [31:0] q;
		wb_xfer(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge clk_i);
	endtask

	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	logic [7:0] ofs [17] = '{OFS_FLAGS, OFS_CONTROL, OFS_COUNT,
		OFS_DIV_LIMIT, OFS_DIV_COUNT, OFS_MATCH_ACT, OFS_MATCH_0,
		OFS_MATCH_1, OFS_MATCH_2, OFS_MATCH_3, OFS_CAP_CTRL,
		OFS_CAPTURE_0, OFS_CAPTURE_1, OFS_EXT_MATCH, OFS_MODE, OFS_PWM,
		8'h34};

	initial begin
		err_count = 0;
		n_compared = 0;
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_wdat = 32'h0;
		cap0 = 1'b0;
		cap1 = 1'b0;
		cyc(8);
		rst_i <= 1'b0;
		cyc(1);
		for (int i = 0; i < 17; i++) rdchk("reset value", ofs[i], 32'h0);
		chk("irq idle", 32'h0, {31'h0, irq_o});
		wr(OFS_DIV_COUNT, 32'hA5A5_0001);
		rdchk("divider_count rw", OFS_DIV_COUNT, 32'hA5A5_0001);
		wr(OFS_DIV_COUNT, 32'h0);
		$display("test reset_and_access done");

		wr(OFS_DIV_LIMIT, 32'h3);
		wr(OFS_MATCH_0, 32'h5);
		wr(OFS_MATCH_ACT, 32'h5);
		wr(OFS_IRQ_MASK, 32'h1);
		rdchk("irq mask rw", OFS_IRQ_MASK, 32'h1);
		wr(OFS_CONTROL, 32'h1);
		n = 0;
		while (irq_o !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
		chk("prescaled period", 32'h1, 32'(n >= 18 && n <= 22));
		rdchk("count at stop", OFS_COUNT, 32'h5);
		rdchk("divider at stop", OFS_DIV_COUNT, 32'h0);
		rdchk("run cleared", OFS_CONTROL, 32'h0);
		rdchk("match0 flag", OFS_FLAGS, 32'h1);
		wr(OFS_FLAGS, 32'h0);
		rdchk("zero write keeps", OFS_FLAGS, 32'h1);
		wr(OFS_FLAGS, 32'h1);
		rdchk("one write clears", OFS_FLAGS, 32'h0);
		cyc(2);
		chk("irq dropped", 32'h0, {31'h0, irq_o});
		$display("test prescale_stop_flag done");

		wr(OFS_DIV_LIMIT, 32'h0);
		wr(OFS_MATCH_1, 32'h2);
		wr(OFS_MATCH_ACT, 32'h18);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CONTROL, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wb_xfer(1'b0, OFS_COUNT, 32'h0, rd);
			chk("reset bound", 32'h1, 32'(rd <= 32'h2));
		end
		wr(OFS_CONTROL, 32'h0);
		rdchk("match1 flag", OFS_FLAGS, 32'h2);
		wr(OFS_FLAGS, 32'h7F);
		$display("test match_reset done");

		wr(OFS_MATCH_ACT, 32'h0);
		wr(OFS_COUNT, 32'hFFFF_FFFD);
		wr(OFS_CONTROL, 32'h1);
		cyc(10);
		wr(OFS_CONTROL, 32'h0);
		wb_xfer(1'b0, OFS_COUNT, 32'h0, rd);
		chk("wrapped", 32'h1, 32'(rd > 32'h0 && rd < 32'h20));
		rdchk("no wrap flag", OFS_FLAGS, 32'h0);
		wr(OFS_CONTROL, 32'h1);
		wr(OFS_CONTROL, 32'h3);
		cyc(3);
		rdchk("cleared count", OFS_COUNT, 32'h0);
		rdchk("cleared divider", OFS_DIV_COUNT, 32'h0);
		wr(OFS_CONTROL, 32'h0);
		$display("test wrap_clear done");

		wr(OFS_COUNT, 32'h1234);
		wr(OFS_CAP_CTRL, 32'h35);
		cap0 <= 1'b1;
		cyc(8);
		rdchk("capture 0", OFS_CAPTURE_0, 32'h1234);
		rdchk("capture0 flag", OFS_FLAGS, 32'h10);
		cap1 <= 1'b1;
		cyc(8);
		rdchk("rise ignored", OFS_CAPTURE_1, 32'h0);
		cap1 <= 1'b0;
		cyc(8);
		rdchk("capture 1", OFS_CAPTURE_1, 32'h1234);
		rdchk("capture1 flag", OFS_FLAGS, 32'h30);
		wr(OFS_CAPTURE_0, 32'hFFFF);
		rdchk("capture read only", OFS_CAPTURE_0, 32'h1234);
		cap0 <= 1'b0;
		wr(OFS_FLAGS, 32'h7F);
		wr(OFS_CAP_CTRL, 32'h0);
		$display("test capture done");

		wr(OFS_MODE, 32'h1);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CONTROL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			cap0 <= 1'b1;
			cyc(4);
			cap0 <= 1'b0;
			cyc(4);
		end
		cyc(4);
		rdchk("edge count", OFS_COUNT, 32'h3);
		wr(OFS_MODE, 32'h6);
		wr(OFS_COUNT, 32'h0);
		for (int m = 0; m < 2; m++) begin
			for (int i = 0; i < 2; i++) begin
				cap1 <= 1'b1;
				cyc(4);
				cap1 <= 1'b0;
				cyc(4);
			end
			cyc(4);
			rdchk("input 1 edges", OFS_COUNT, m ? 32'h6 : 32'h2);
			wr(OFS_MODE, 32'h7);
		end
		wr(OFS_CONTROL, 32'h0);
		wr(OFS_MODE, 32'h0);
		$display("test counter_mode done");

		wr(OFS_MATCH_2, 32'h3);
		wr(OFS_MATCH_ACT, 32'h100);
		wr(OFS_EXT_MATCH, 32'h300);
		wr(OFS_COUNT, 32'h0);
		wr(OFS_CONTROL, 32'h1);
		cyc(20);
		rdchk("stop on match2", OFS_COUNT, 32'h3);
		chk("toggled pin", 32'h1, {31'h0, match_output_o[2]});
		rdchk("ext state", OFS_EXT_MATCH, 32'h304);
		wr(OFS_PWM, 32'h8);
		wr(OFS_MATCH_3, 32'h10);
		wr(OFS_COUNT, 32'h20);
		cyc(3);
		chk("pwm high", 32'h1, {31'h0, match_output_o[3]});
		wr(OFS_COUNT, 32'h8);
		cyc(3);
		chk("pwm low", 32'h0, {31'h0, match_output_o[3]});
		$display("test ext_match_pwm done");
		conclude();
	end

	initial begin
		#200000;
		err_count++;
		$display("mismatch watchdog expected done seen hang");
		conclude();
	end
endmodule
